// ### pkg/rup_defines.svh
// constants for the remote update user port: field positions, resets, timing
// assumes a single user clock of 200 MHz driving every flop of the port
`ifndef RUP_DEFINES_SVH
`define RUP_DEFINES_SVH

// ----------------------------------------------------------------------
// shift register and timing
// ----------------------------------------------------------------------
`define RUP_SHIFT_W        32
`define RUP_CLK_PERIOD_NS  5
`define RUP_KICK_MIN_NS    250
// least time, rounded up to whole cycles
`define RUP_KICK_MIN_CYC   ((`RUP_KICK_MIN_NS + `RUP_CLK_PERIOD_NS - 1) / `RUP_CLK_PERIOD_NS)
`define RUP_WDOG_W         24

// ----------------------------------------------------------------------
// control word fields (update direction)
// ----------------------------------------------------------------------
`define RUP_CTL_OVERRIDE   0
`define RUP_CTL_IMG_SEL    1
`define RUP_CTL_WDOG_EN    2
`define RUP_CTL_LIMIT_LO   8
`define RUP_CTL_LIMIT_HI   31
`define RUP_CTL_RESET      32'h0000_0000

// ----------------------------------------------------------------------
// status word fields (capture direction)
// ----------------------------------------------------------------------
`define RUP_ST_CUR_IMG     0
`define RUP_ST_WDOG_CAUSE  1
`define RUP_ST_USER_CAUSE  2
`define RUP_ST_SHORT_KICK  3
`define RUP_ST_FIRST_ONLY  4
`define RUP_ST_OVR_ACTIVE  5

`endif

// ### pkg/rup_pkg.sv
// types shared by the remote update user port modules
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package rup_pkg;
  // reconfiguration sequencer, gray along run -> reconfig
  typedef enum logic [0:0] {
    RUP_RUN      = 1'b0,
    RUP_RECONFIG = 1'b1
  } rup_state_t;
endpackage
`default_nettype wire

// ### pkg/rup_wdog_if.sv
// carrier between the port top and its watchdog counter
// assumes both ends sit on the same user clock
`default_nettype none
interface rup_wdog_if;
  logic                    clear;
  logic                    enable;
  logic [23:0]             limit;
  logic                    expired;
  modport ctl (output clear, output enable, output limit, input expired);
  modport wdg (input clear, input enable, input limit, output expired);
endinterface
`default_nettype wire

// ### logic/rup_watchdog.sv
// user watchdog counter of the remote update port
// assumes clear is a one-cycle pulse from the same clock domain
`include "rup_defines.svh"
`default_nettype none
module rup_watchdog (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  rup_wdog_if.wdg   wd
);
  logic [`RUP_WDOG_W-1:0] cnt_r;
  logic                   expired_r;

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  // count while enabled; a kick or disable restarts from zero
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || wd.clear || !wd.enable) begin
      cnt_r <= '0;
    end else if (cnt_r != wd.limit) begin
      cnt_r <= cnt_r + `RUP_WDOG_W'(1);
    end
  end

  // expiry holds until kicked or disabled, so the top sees a clean edge
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || wd.clear || !wd.enable) begin
      expired_r <= 1'b0;
    end else if (cnt_r == wd.limit) begin
      expired_r <= 1'b1;
    end
  end

  assign wd.expired = expired_r;
endmodule
`default_nettype wire

// ### logic/rup_port.sv
// remote update user port: serial access to control and status words,
// watchdog kick and reconfiguration request from core logic
// assumes every input comes from core logic on clock_i, so none is synchronised
//
// Contract
// - all loads and outputs on rising clock
// - shift mode moves one bit per edge
// - capture-not-update picks readback or write
// - falling kick edge restarts user watchdog
// - rising reconfiguration request starts reconfiguration
// - serial output is one shift register bit
// - image override only after first-image-only load
`include "rup_defines.svh"
`default_nettype none
module rup_port #(
  parameter int SHIFT_W = `RUP_SHIFT_W
) (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic shift_not_load_i,
  input  wire logic capture_not_update_i,
  input  wire logic serial_in_i,
  input  wire logic watchdog_kick_n_i,
  input  wire logic reconfig_req_i,
  input  wire logic current_image_i,
  input  wire logic default_image_i,
  input  wire logic first_image_only_i,
  output var  logic serial_out_o,
  output var  logic reconfig_o,
  output var  logic next_image_o,
  output var  logic watchdog_expired_o
);
  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam logic [7:0] KICK_MIN = 8'(`RUP_KICK_MIN_CYC);

  rup_wdog_if wd_if ();

  logic [SHIFT_W-1:0]     shift_r;
  logic [SHIFT_W-1:0]     ctl_r;
  logic [SHIFT_W-1:0]     status_w;
  logic                   first_only_r;
  logic                   kick_prev_r;
  logic                   req_prev_r;
  logic                   exp_prev_r;
  logic [7:0]             low_cnt_r;
  logic                   short_kick_r;
  logic                   wdog_cause_r;
  logic                   user_cause_r;
  logic                   reconfig_r;
  logic                   next_image_r;
  logic                   kick_fall;
  logic                   kick_rise;
  logic                   req_rise;
  logic                   exp_rise;
  logic                   do_capture;
  logic                   do_update;
  logic                   ovr_active;
  rup_pkg::rup_state_t    state_r;
  rup_pkg::rup_state_t    state_nxt;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // one edge test shared by the request, kick and expiry paths
  function automatic logic rose(input logic prev, input logic cur);
    rose = cur & ~prev;
  endfunction

  // ----------------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------------
  // the first-image-only setting is caught while reset is held and
  // stays fixed afterwards, like a boot option
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      first_only_r <= first_image_only_i;
    end
  end

  // ----------------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------------
  // kick idles high, so reset to high to avoid a false rising edge
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      kick_prev_r <= 1'b1;
      req_prev_r  <= 1'b0;
      exp_prev_r  <= 1'b0;
    end else begin
      kick_prev_r <= watchdog_kick_n_i;
      req_prev_r  <= reconfig_req_i;
      exp_prev_r  <= wd_if.expired;
    end
  end

  // edge strobes, all one cycle wide
  assign kick_fall = rose(watchdog_kick_n_i, kick_prev_r);
  assign kick_rise = rose(kick_prev_r, watchdog_kick_n_i);
  assign req_rise  = rose(req_prev_r, reconfig_req_i);
  assign exp_rise  = rose(exp_prev_r, wd_if.expired);

  // ----------------------------------------------------------------------
  // transfer decode
  // ----------------------------------------------------------------------
  // load mode split
  assign do_capture = ~shift_not_load_i & capture_not_update_i;
  assign do_update  = ~shift_not_load_i & ~capture_not_update_i;

  assign ovr_active = first_only_r & ~current_image_i & ctl_r[`RUP_CTL_OVERRIDE];

  // status word seen by a capture; unused bits read as zero
  always_comb begin
    status_w                      = '0;
    status_w[`RUP_ST_CUR_IMG]     = current_image_i;
    status_w[`RUP_ST_WDOG_CAUSE]  = wdog_cause_r;
    status_w[`RUP_ST_USER_CAUSE]  = user_cause_r;
    status_w[`RUP_ST_SHORT_KICK]  = short_kick_r;
    status_w[`RUP_ST_FIRST_ONLY]  = first_only_r;
    status_w[`RUP_ST_OVR_ACTIVE]  = ovr_active;
  end

  // ----------------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------------
  // rising edge only
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      shift_r <= '0;
    end else if (shift_not_load_i) begin
      shift_r <= {serial_in_i, shift_r[SHIFT_W-1:1]};
    end else if (do_capture) begin
      shift_r <= status_w;
    end
  end

  assign serial_out_o = shift_r[0];

  // ----------------------------------------------------------------------
  // control word
  // ----------------------------------------------------------------------
  // update selects write
  // parallel update
  // update copies the whole word; the shift register keeps its content so
  // a following capture is needed to see the effect
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ctl_r <= SHIFT_W'(`RUP_CTL_RESET);
    end else if (do_update) begin
      ctl_r <= shift_r;
    end
  end

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  // falling kick restarts
  assign wd_if.clear  = kick_fall;
  assign wd_if.enable = ctl_r[`RUP_CTL_WDOG_EN];
  assign wd_if.limit  = ctl_r[`RUP_CTL_LIMIT_HI:`RUP_CTL_LIMIT_LO];

  rup_watchdog u_watchdog (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .wd        (wd_if)
  );

  // low time monitor
  // a kick is acted on at once; a too-short pulse is only reported
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || watchdog_kick_n_i) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != KICK_MIN) begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end

  // sticky short-kick flag; a new event wins over the capture that clears it
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      short_kick_r <= 1'b0;
    end else if (kick_rise && (low_cnt_r < KICK_MIN)) begin
      short_kick_r <= 1'b1;
    end else if (do_capture) begin
      short_kick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // reconfiguration sequencer
  // ----------------------------------------------------------------------
  // request edge starts
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rup_pkg::RUP_RUN: begin
        if (req_rise || exp_rise) begin
          state_nxt = rup_pkg::RUP_RECONFIG;
        end
      end
      rup_pkg::RUP_RECONFIG: begin
        state_nxt = rup_pkg::RUP_RECONFIG;
      end
      default: begin
        state_nxt = rup_pkg::RUP_RUN;
      end
    endcase
  end

  // once reconfiguring, only a reset brings the port back
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_r <= rup_pkg::RUP_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cause flags record what started the reconfiguration
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      wdog_cause_r <= 1'b0;
      user_cause_r <= 1'b0;
    end else if (state_r == rup_pkg::RUP_RUN) begin
      wdog_cause_r <= exp_rise;
      user_cause_r <= req_rise;
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  // image choice
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      reconfig_r         <= 1'b0;
      next_image_r       <= 1'b0;
      watchdog_expired_o <= 1'b0;
    end else begin
      reconfig_r         <= (state_nxt == rup_pkg::RUP_RECONFIG);
      watchdog_expired_o <= wd_if.expired;
      if (ovr_active) begin
        next_image_r <= ctl_r[`RUP_CTL_IMG_SEL];
      end else begin
        next_image_r <= first_only_r ? 1'b0 : default_image_i;
      end
    end
  end

  assign reconfig_o   = reconfig_r;
  assign next_image_o = next_image_r;
endmodule
`default_nettype wire

// ### tb/rup_port_properties.sv
// checker for the remote update user port, bound to its top
// assumes one user clock and a synchronous active-low reset
`default_nettype none
module rup_port_properties (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic shift_not_load_i,
  input wire logic capture_not_update_i,
  input wire logic serial_in_i,
  input wire logic watchdog_kick_n_i,
  input wire logic reconfig_req_i,
  input wire logic current_image_i,
  input wire logic default_image_i,
  input wire logic first_image_only_i,
  input wire logic serial_out_o,
  input wire logic reconfig_o,
  input wire logic next_image_o,
  input wire logic watchdog_expired_o
);
  logic [5:0] run_r;
  logic       strap_r;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // shift run length, saturating so the pipe check stays armed
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !shift_not_load_i) begin
      run_r <= 6'h00;
    end else if (run_r != 6'h3f) begin
      run_r <= run_r + 6'h01;
    end
  end
  // strap copy, frozen once reset lets go
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      strap_r <= first_image_only_i;
    end
  end
  chk_shift_pipe: assert property (
    run_r >= 6'h20 |-> serial_out_o == $past(serial_in_i, 32))
    else $error("shifted bit lost");
  chk_update_keeps: assert property (
    !shift_not_load_i && !capture_not_update_i |=> $stable(serial_out_o))
    else $error("update moved the shift register");
  chk_capture_image: assert property (
    !shift_not_load_i && capture_not_update_i |=> serial_out_o == $past(current_image_i))
    else $error("capture lost the running image");
  chk_req_starts: assert property (
    $rose(reconfig_req_i) && !reconfig_o |-> ##[1:2] reconfig_o)
    else $error("request did not start reconfiguration");
  chk_reconfig_sticky: assert property (
    reconfig_o |=> reconfig_o)
    else $error("reconfiguration dropped");
  chk_kick_clears: assert property (
    $fell(watchdog_kick_n_i) |=> ##1 !watchdog_expired_o)
    else $error("kick did not clear expiry");
  chk_image_default: assert property (
    !strap_r |=> next_image_o == $past(default_image_i))
    else $error("next image not the default");
  chk_expiry_reconfig: assert property (
    $rose(watchdog_expired_o) |-> ##[0:1] reconfig_o)
    else $error("expiry did not reconfigure");
  // main scenarios reached
  cover property (run_r == 6'h20);
  cover property ($rose(reconfig_o));
  cover property ($fell(watchdog_kick_n_i));
  cover property ($fell(watchdog_kick_n_i) && watchdog_expired_o);
endmodule

bind rup_port rup_port_properties rup_port_properties_i (.clock_i(clock_i),
  .reset_n_i(reset_n_i), .shift_not_load_i(shift_not_load_i),
  .capture_not_update_i(capture_not_update_i), .serial_in_i(serial_in_i),
  .watchdog_kick_n_i(watchdog_kick_n_i), .reconfig_req_i(reconfig_req_i),
  .current_image_i(current_image_i), .default_image_i(default_image_i),
  .first_image_only_i(first_image_only_i), .serial_out_o(serial_out_o),
  .reconfig_o(reconfig_o), .next_image_o(next_image_o),
  .watchdog_expired_o(watchdog_expired_o));
`default_nettype wire

// ### tb/rup_core_model.sv
// core logic model: gives the watchdog kick as a timed low pulse
// assumes the port's user clock and a one-cycle request
`default_nettype none
module rup_core_model #(
  parameter int KICK_CYC = 50
) (
  input  wire logic clock_i,
  input  wire logic kick_go_i,
  output wire logic watchdog_kick_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_r = 0;
  // kick held 250 ns, exactly the minimum
  always @(posedge clock_i) begin
    if (kick_go_i && low_r == 0) begin
      low_r <= KICK_CYC;
    end else if (low_r != 0) begin
      low_r <= low_r - 1;
    end
  end
  assign watchdog_kick_n_o = (low_r == 0);
endmodule
`default_nettype wire

// ### tb/rup_port_tb.sv
// self-checking bench for the remote update user port
// assumes the core model is the only driver of the kick line
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %b want %b", $time, a, b); end end
module rup_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, reset_n_i, shift_not_load_i, capture_not_update_i, serial_in_i;
  logic reconfig_req_i, current_image_i, default_image_i, first_image_only_i, kick_go;
  wire  kick_n, serial_out_o, reconfig_o, next_image_o, watchdog_expired_o;
  int   bad_count, compares, seed, n;
  logic [31:0] w, prev;

  // 200 MHz user clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  rup_port rup_port_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .shift_not_load_i(shift_not_load_i), .capture_not_update_i(capture_not_update_i),
    .serial_in_i(serial_in_i), .watchdog_kick_n_i(kick_n), .reconfig_req_i(reconfig_req_i),
    .current_image_i(current_image_i), .default_image_i(default_image_i),
    .first_image_only_i(first_image_only_i), .serial_out_o(serial_out_o),
    .reconfig_o(reconfig_o), .next_image_o(next_image_o),
    .watchdog_expired_o(watchdog_expired_o));
  rup_core_model rup_core_model_i (.clock_i(clock_i), .kick_go_i(kick_go),
    .watchdog_kick_n_o(kick_n));

  // expected status word; override never active where it is read
  function automatic logic [31:0] stat(input logic img, wd, usr, strap);
    return {27'h000_0000, strap, 1'b0, usr, wd, img};
  endfunction

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // reset with idle capture, strap sampled meanwhile
  task automatic rst(input logic strap);
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    first_image_only_i <= strap;
    capture_not_update_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1'b1;
  endtask

  // 32 shifts: edge p0 loads, the word read is the one loaded there
  task automatic xfer(input logic [31:0] din, input logic [31:0] exp, input logic tail);
    for (int i = 0; i < 32; i++) begin
      @(posedge clock_i);
      shift_not_load_i <= 1'b1;
      serial_in_i <= din[i];
      @(negedge clock_i);
      `CHK(serial_out_o, exp[i])
    end
    @(posedge clock_i);
    shift_not_load_i <= 1'b0;
    capture_not_update_i <= tail;
  endtask

  task automatic kick;
    @(posedge clock_i);
    kick_go <= 1'b1;
    @(posedge clock_i);
    kick_go <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
  endtask

  initial begin
    seed = 67;
    {reset_n_i, shift_not_load_i, serial_in_i, reconfig_req_i, kick_go} = 5'h00;
    {current_image_i, default_image_i, capture_not_update_i} = 3'b001;
    first_image_only_i = 1'b1;
    rst(1'b1);
    // random words, read back next pass; with the override bit set, the image-select bit picks the image
    prev = stat(1'b0, 1'b0, 1'b0, 1'b1);
    for (int k = 0; k < 6; k++) begin
      w = $random(seed) & 32'hffff_fffb;
      if (k < 2) w[1:0] = (k == 0) ? 2'b11 : 2'b01;
      xfer(w, prev, 1'b0);
      prev = w;
      settle();
      `CHK(next_image_o, w[0] & w[1])
    end
    @(posedge clock_i);
    current_image_i <= 1'b1;
    settle();
    `CHK(next_image_o, 1'b0)
    $display("test shift and override done");
    // watchdog limit 200 cycles, kicked twice, then left to run out
    xfer(32'h0000_c804, prev, 1'b0);
    repeat (2) begin
      kick();
      repeat (100) @(posedge clock_i);
    end
    @(negedge clock_i);
    `CHK(reconfig_o, 1'b0)
    n = 0;
    while (reconfig_o !== 1'b1 && n < 300) begin
      @(negedge clock_i);
      n++;
    end
    `CHK(n < 300, 1'b1)
    @(negedge clock_i);
    `CHK(watchdog_expired_o, 1'b1)
    // a kick after expiry must drop it; wait out the pulse so it never reads short
    kick();
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    `CHK(watchdog_expired_o, 1'b0)
    repeat (60) @(posedge clock_i);
    @(posedge clock_i);
    capture_not_update_i <= 1'b1;
    xfer($random(seed), stat(1'b1, 1'b1, 1'b0, 1'b1), 1'b1);
    $display("test watchdog done");
    // default image path and a user reconfiguration request
    rst(1'b0);
    w = $random(seed);
    default_image_i <= w[5];
    current_image_i <= w[6];
    settle();
    `CHK(next_image_o, w[5])
    `CHK(reconfig_o, 1'b0)
    @(posedge clock_i);
    reconfig_req_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    `CHK(reconfig_o, 1'b1)
    xfer(w, stat(w[6], 1'b0, 1'b1, 1'b0), 1'b1);
    $display("test request done");
    wrap_up();
  end
endmodule
`default_nettype wire
